// [logic/flash_protect_option_loader.sv]
`timescale 1ns/100ps
// Summary of operation
// - Write at shared address hits lock mask only right after 5Eh while locked.
// - Lock mask holds eight sector bits, all zero after reset.
// - A set lock bit cannot be cleared by software until reset.
// - Number of implemented lock bits is a parameter.
// - High and low clock bytes form one 16-bit kHz value.
// - Option bytes reload on every reset and stop recovery before CPU runs.
// - Changed option bytes apply only after a reset or a stop-mode recovery reload.
// - Option registers are invisible to software reads and writes.
// - User option bytes come from program addresses 0 and 1.
// - Thirty-two trim bytes; only trim bytes 0 to 10 live in the information page, fixed in flash.
// - Trim index write, then trim data write replaces that working byte.
// - Trim index write, then trim data read returns that working byte.
// - Software trim changes are volatile; trim bytes 0 to 10 reload from flash, the rest only clear on reset.
// - Trim index adds a fixed offset; other info locations unreachable.
// - Loader does 43 accesses, six-bit counter address, upper bits zero.
// - Option bytes latch flash data at loader addresses, up to 344 bits.
// - Loader addresses 0 and 1 from program memory, rest from info area.
// - Page select holds info area enable in bit 7 and 7-bit page.
module flash_protect_option_loader
    import flash_opt_pkg::*;
#(
    parameter int PROT_BITS = 8,
    parameter int SECTOR_PAGE_SHIFT = 1,
    parameter int OPT_BYTES = LOAD_COUNT
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Register port
    input wire logic [11:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Stop-mode recovery restart
    input wire logic i_stop_recover,
    // Flash array read for the loader
    output logic o_flash_rd,
    output logic [15:0] o_flash_addr,
    output logic o_flash_info,
    input wire logic [7:0] i_flash_data,
    // Loaded option configuration
    output logic [OPT_BYTES*8-1:0] o_option_bytes,
    output logic o_cpu_hold,
    // Program and erase timing and page selection
    output logic [15:0] o_flash_clock_khz,
    output logic [6:0] o_page_select,
    output logic o_info_area_select,
    output logic [7:0] o_sector_lock_mask,
    // Program or erase request check
    input wire logic i_op_req,
    input wire logic [6:0] i_op_page,
    input wire logic i_op_info,
    output logic o_op_allow,
    output logic o_op_blocked
);

    // Array depth covers every slot the loader counter can reach
    localparam int OPT_SPACE = 1 << LOAD_AW;
    // Lock register width; only the low PROT_BITS sectors are implemented
    localparam int LOCK_BITS = 8;
    // Loader address bits above the counter stay at zero
    localparam int FLASH_AW = 16;
    localparam logic [FLASH_AW-LOAD_AW-1:0] FETCH_UPPER = '0;

    // Register state
    cmd_state_t cmd_state_q;
    cmd_state_t cmd_state_d;
    logic [7:0] lock_mask_q;
    logic [6:0] page_q;
    logic info_sel_q;
    logic [7:0] khz_high_q;
    logic [7:0] khz_low_q;
    logic [7:0] trim_index_q;
    logic [7:0] rdata_q;
    logic [7:0] opt_q [OPT_SPACE];

    // Loader sequencer outputs
    logic fetch_en;
    logic [LOAD_AW-1:0] fetch_addr;
    logic cap_en;
    logic [LOAD_AW-1:0] cap_idx;
    logic loader_busy;

    // Register decode and trim window
    logic wr_cmd;
    logic wr_shared;
    logic wr_lock;
    logic wr_page;
    logic trim_ok;
    logic [LOAD_AW-1:0] trim_slot;

    // Op check helpers
    logic [6:0] op_sector_full;
    logic [LOCK_BITS-1:0] sector_hit;
    logic op_locked;

    // Qualified software strobes, one per writable register
    logic sw_wr;
    logic wr_khz_high;
    logic wr_khz_low;
    logic wr_trim_index;
    logic wr_trim_value;
    logic [LOCK_BITS-1:0] lock_set;

    // Read mux output and the two composed read bytes
    logic [7:0] rdata_d;
    logic [7:0] status_byte;
    logic [7:0] shared_byte;

    // Status code shown for each command state
    function automatic logic [5:0] status_code(input cmd_state_t st);
        case (st)
            CS_LOCKED: status_code = STAT_LOCKED;
            CS_FIRST: status_code = STAT_FIRST;
            CS_SECOND: status_code = STAT_SECOND;
            CS_UNLOCKED: status_code = STAT_UNLOCKED;
            CS_SECTOR: status_code = STAT_SECTOR;
            default: status_code = STAT_LOCKED;
        endcase
    endfunction

    // Address match for one register, shared by every write decode
    function automatic logic reg_hit(
        input logic strobe,
        input logic [11:0] addr,
        input logic [11:0] target
    );
        reg_hit = strobe && (addr == target);
    endfunction

    // Loader sequencer, restarted by stop-mode recovery
    option_fetch #(
        .COUNT(LOAD_COUNT),
        .AW(LOAD_AW)
    ) u_fetch (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_start(i_stop_recover),
        .o_fetch_en(fetch_en),
        .o_fetch_addr(fetch_addr),
        .o_cap_en(cap_en),
        .o_cap_idx(cap_idx),
        .o_busy(loader_busy)
    );

    // Flash address, only the low six bits come from the counter
    assign o_flash_rd = fetch_en;
    assign o_flash_addr = {FETCH_UPPER, fetch_addr};
    assign o_flash_info = fetch_en && (fetch_addr > LAST_PROGRAM_ADDR);
    assign o_cpu_hold = loader_busy | i_stop_recover;

    // Register decode; software writes are ignored while the CPU is held
    assign sw_wr = i_wr && !o_cpu_hold;
    assign wr_cmd = reg_hit(sw_wr, i_addr, FLASH_CMD_ADDR);
    assign wr_shared = reg_hit(sw_wr, i_addr, SECTOR_PAGE_ADDR);
    // Shared address reaches the lock mask only straight after the select command
    assign wr_lock = wr_shared && (cmd_state_q == CS_SECTOR);
    assign wr_page = wr_shared && (cmd_state_q != CS_SECTOR);

    // Frequency and trim strobes
    assign wr_khz_high = reg_hit(sw_wr, i_addr, CLOCK_KHZ_HIGH_ADDR);
    assign wr_khz_low = reg_hit(sw_wr, i_addr, CLOCK_KHZ_LOW_ADDR);
    assign wr_trim_index = reg_hit(sw_wr, i_addr, TRIM_INDEX_ADDR);
    // Trim data write lands only while the index is inside the window
    assign wr_trim_value = reg_hit(sw_wr, i_addr, TRIM_VALUE_ADDR) && trim_ok;

    // Trim index range check and offset into the info area
    assign trim_ok = trim_index_q < TRIM_COUNT;
    assign trim_slot = TRIM_BASE + trim_index_q[LOAD_AW-1:0];

    // Command state: unlock pair, sector select only from locked
    always_comb begin
        cmd_state_d = cmd_state_q;
        if (wr_cmd) begin
            cmd_state_d = CS_LOCKED;
            case (cmd_state_q)
                CS_LOCKED: begin
                    if (i_wdata == CMD_UNLOCK_FIRST) begin
                        cmd_state_d = CS_FIRST;
                    end else if (i_wdata == CMD_SECTOR_SELECT) begin
                        cmd_state_d = CS_SECTOR;
                    end
                end
                CS_FIRST: begin
                    if (i_wdata == CMD_UNLOCK_SECOND) begin
                        cmd_state_d = CS_SECOND;
                    end
                end
                CS_SECOND: cmd_state_d = CS_LOCKED;
                CS_UNLOCKED: cmd_state_d = CS_LOCKED;
                default: cmd_state_d = CS_LOCKED;
            endcase
        end else if (cmd_state_q == CS_SECOND) begin
            cmd_state_d = CS_UNLOCKED;
        end else if (wr_shared && cmd_state_q == CS_SECTOR) begin
            cmd_state_d = CS_LOCKED;
        end
    end

    // Command state register
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cmd_state_q <= CS_LOCKED;
        end else begin
            cmd_state_q <= cmd_state_d;
        end
    end

    // Per-sector set requests; sectors past PROT_BITS never latch
    generate
        for (genvar s = 0; s < LOCK_BITS; s++) begin : g_lock_set
            if (s < PROT_BITS) begin : g_used
                assign lock_set[s] = wr_lock && i_wdata[s];
            end else begin : g_unused
                assign lock_set[s] = 1'b0;
            end
        end
    endgenerate

    // Sector lock mask, bits only ever set until the next reset
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lock_mask_q <= BYTE_RESET;
        end else begin
            lock_mask_q <= lock_mask_q | lock_set;
        end
    end

    // Page select and info area enable
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            page_q <= PAGE_RESET;
            info_sel_q <= 1'b0;
        end else if (wr_page) begin
            page_q <= i_wdata[6:0];
            info_sel_q <= i_wdata[INFO_SEL_BIT];
        end
    end

    // Clock frequency bytes
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            khz_high_q <= BYTE_RESET;
            khz_low_q <= BYTE_RESET;
        end else begin
            if (wr_khz_high) begin
                khz_high_q <= i_wdata;
            end
            if (wr_khz_low) begin
                khz_low_q <= i_wdata;
            end
        end
    end

    // Trim index
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            trim_index_q <= BYTE_RESET;
        end else if (wr_trim_index) begin
            trim_index_q <= i_wdata;
        end
    end

    // Option and working trim bytes; loader capture beats software
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < OPT_SPACE; i++) begin
                opt_q[i] <= BYTE_RESET;
            end
        end else if (cap_en) begin
            opt_q[cap_idx] <= i_flash_data;
        end else if (wr_trim_value) begin
            opt_q[trim_slot] <= i_wdata;
        end
    end

    // Status byte keeps the reserved top bits at zero; shared address shows lock or page
    assign status_byte = {2'b00, status_code(cmd_state_q)};
    assign shared_byte = (cmd_state_q == CS_SECTOR) ? lock_mask_q : {info_sel_q, page_q};

    // Read mux; unmapped addresses and idle cycles give zero
    always_comb begin
        rdata_d = BYTE_RESET;
        if (i_rd) begin
            case (i_addr)
                TRIM_INDEX_ADDR: rdata_d = trim_index_q;
                TRIM_VALUE_ADDR: rdata_d = trim_ok ? opt_q[trim_slot] : BYTE_RESET;
                FLASH_CMD_ADDR: rdata_d = status_byte;
                SECTOR_PAGE_ADDR: rdata_d = shared_byte;
                CLOCK_KHZ_HIGH_ADDR: rdata_d = khz_high_q;
                CLOCK_KHZ_LOW_ADDR: rdata_d = khz_low_q;
                default: rdata_d = BYTE_RESET;
            endcase
        end
    end

    // Read data register, standing only in the cycle after the strobe
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_q <= BYTE_RESET;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Loaded option bytes out to the device configuration
    genvar g;
    generate
        for (g = 0; g < OPT_BYTES; g++) begin : g_opt
            assign o_option_bytes[g*8 +: 8] = opt_q[g];
        end
    endgenerate

    // Sector of the targeted page
    assign op_sector_full = i_op_page >> SECTOR_PAGE_SHIFT;

    // One match per sector, so pages past the implemented sectors carry no lock
    generate
        for (genvar s = 0; s < LOCK_BITS; s++) begin : g_sector_hit
            assign sector_hit[s] = (op_sector_full == 7'(s)) && lock_mask_q[s];
        end
    endgenerate
    assign op_locked = |sector_hit;

    // Program or erase check against the lock mask; protect bits are not touched
    assign o_op_blocked = i_op_req && !i_op_info && op_locked;
    assign o_op_allow = i_op_req && !o_op_blocked;

    // Plain outputs
    assign o_rdata = rdata_q;
    assign o_flash_clock_khz = {khz_high_q, khz_low_q};
    assign o_page_select = page_q;
    assign o_info_area_select = info_sel_q;
    assign o_sector_lock_mask = lock_mask_q;

endmodule // flash_protect_option_loader

// [logic/flash_opt_pkg.sv]
package flash_opt_pkg;

    // Register offsets on the register port
    localparam logic [11:0] TRIM_INDEX_ADDR = 12'hff6;
    localparam logic [11:0] TRIM_VALUE_ADDR = 12'hff7;
    localparam logic [11:0] FLASH_CMD_ADDR = 12'hff8;
    localparam logic [11:0] SECTOR_PAGE_ADDR = 12'hff9;
    localparam logic [11:0] CLOCK_KHZ_HIGH_ADDR = 12'hffa;
    localparam logic [11:0] CLOCK_KHZ_LOW_ADDR = 12'hffb;

    // Reset values
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [6:0] PAGE_RESET = 7'h00;

    // Flash command bytes
    localparam logic [7:0] CMD_UNLOCK_FIRST = 8'h73;
    localparam logic [7:0] CMD_UNLOCK_SECOND = 8'h8c;
    localparam logic [7:0] CMD_SECTOR_SELECT = 8'h5e;

    // Status codes shown in the low six bits of the status read
    localparam logic [5:0] STAT_LOCKED = 6'h00;
    localparam logic [5:0] STAT_FIRST = 6'h01;
    localparam logic [5:0] STAT_SECOND = 6'h02;
    localparam logic [5:0] STAT_UNLOCKED = 6'h03;
    localparam logic [5:0] STAT_SECTOR = 6'h04;

    // Page select layout
    localparam int INFO_SEL_BIT = 7;

    // Loader geometry
    localparam int LOAD_COUNT = 43;
    localparam int LOAD_AW = 6;
    localparam logic [5:0] LAST_PROGRAM_ADDR = 6'h01;
    localparam logic [5:0] TRIM_BASE = 6'h20;
    localparam logic [7:0] TRIM_COUNT = 8'h20;

    // Flash controller command state
    typedef enum logic [2:0] {
        CS_LOCKED,
        CS_FIRST,
        CS_SECOND,
        CS_UNLOCKED,
        CS_SECTOR
    } cmd_state_t;

endpackage

// [logic/option_fetch.sv]
`timescale 1ns/100ps
module option_fetch
    import flash_opt_pkg::*;
#(
    parameter int COUNT = LOAD_COUNT,
    parameter int AW = LOAD_AW
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Restart request
    input wire logic i_start,
    // Flash read side
    output logic o_fetch_en,
    output logic [AW-1:0] o_fetch_addr,
    // Capture side, data arrives one cycle after the address
    output logic o_cap_en,
    output logic [AW-1:0] o_cap_idx,
    output logic o_busy
);

    localparam logic [AW-1:0] LAST_IDX = AW'(COUNT - 1);

    logic fetch_q;
    logic [AW-1:0] cnt_q;
    logic cap_q;
    logic [AW-1:0] cap_idx_q;

    // Address counter, one flash access per clock while fetching
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fetch_q <= 1'b1;
            cnt_q <= '0;
        end else if (i_start) begin
            fetch_q <= 1'b1;
            cnt_q <= '0;
        end else if (fetch_q) begin
            if (cnt_q == LAST_IDX) begin
                fetch_q <= 1'b0;
            end
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // Capture strobe trails the address by one cycle
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cap_q <= 1'b0;
            cap_idx_q <= '0;
        end else begin
            cap_q <= fetch_q & ~i_start;
            cap_idx_q <= cnt_q;
        end
    end

    assign o_fetch_en = fetch_q;
    assign o_fetch_addr = cnt_q;
    assign o_cap_en = cap_q;
    assign o_cap_idx = cap_idx_q;
    assign o_busy = fetch_q | cap_q;

endmodule // option_fetch

// [dv/flash_loader_monitor.sv]
`timescale 1ns/100ps
module flash_loader_checker
    import flash_opt_pkg::*;
#(
    parameter int SECTOR_PAGE_SHIFT = 1
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Register port
    input wire logic [11:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    // Loader
    input wire logic i_stop_recover,
    input wire logic o_flash_rd,
    input wire logic [15:0] o_flash_addr,
    input wire logic o_flash_info,
    input wire logic o_cpu_hold,
    // Timing, protection and op check
    input wire logic [15:0] o_flash_clock_khz,
    input wire logic [7:0] o_sector_lock_mask,
    input wire logic i_op_req,
    input wire logic [6:0] i_op_page,
    input wire logic i_op_info,
    input wire logic o_op_allow,
    input wire logic o_op_blocked
);
    logic [6:0] sector;

    // Sector targeted by the op check
    assign sector = i_op_page >> SECTOR_PAGE_SHIFT;

    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    chk_addr_upper: assert property (o_flash_addr[15:6] == 10'h000)
        else $error("loader address upper bits not zero");
    chk_info_split: assert property (o_flash_rd |-> o_flash_info == (o_flash_addr[5:0] > 6'h01))
        else $error("loader area select wrong");
    chk_addr_step: assert property (i_rst_n && o_flash_rd && !i_stop_recover
        && o_flash_addr[5:0] < 6'd42 |=> o_flash_addr[5:0] == $past(o_flash_addr[5:0]) + 6'h01)
        else $error("loader address did not step");
    chk_load_len: assert property (o_flash_rd && o_flash_addr[5:0] == 6'd42 && !i_stop_recover
        |=> !o_flash_rd)
        else $error("loader ran past last access");
    chk_hold_release: assert property ($fell(o_cpu_hold) |-> !$past(o_flash_rd) && $past(o_flash_rd, 2))
        else $error("cpu hold released at wrong time");
    chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside read answer cycle");
    chk_lock_sticky: assert property (($past(o_sector_lock_mask) & ~o_sector_lock_mask) == 8'h00)
        else $error("lock bit cleared");
    chk_khz_high: assert property (i_wr && i_addr == CLOCK_KHZ_HIGH_ADDR && !o_cpu_hold
        |=> o_flash_clock_khz[15:8] == $past(i_wdata))
        else $error("clock high byte not on top");
    chk_op_block: assert property (i_op_req && !i_op_info && sector < 7'd8
        && o_sector_lock_mask[sector[2:0]] |-> o_op_blocked && !o_op_allow)
        else $error("op into locked sector allowed");
endmodule // flash_loader_checker

bind flash_protect_option_loader flash_loader_checker #(.SECTOR_PAGE_SHIFT(SECTOR_PAGE_SHIFT)) u_chk (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_stop_recover(i_stop_recover), .o_flash_rd(o_flash_rd),
    .o_flash_addr(o_flash_addr), .o_flash_info(o_flash_info), .o_cpu_hold(o_cpu_hold),
    .o_flash_clock_khz(o_flash_clock_khz), .o_sector_lock_mask(o_sector_lock_mask),
    .i_op_req(i_op_req), .i_op_page(i_op_page), .i_op_info(i_op_info),
    .o_op_allow(o_op_allow), .o_op_blocked(o_op_blocked));

// [dv/flash_array_model.sv]
`timescale 1ns/100ps
module flash_array_model (
    // Clock
    input wire logic i_mclk,
    // Read request and content variant
    input wire logic i_rd,
    input wire logic [15:0] i_addr,
    input wire logic i_info,
    input wire logic i_alt,
    // Data one cycle after the address
    output logic [7:0] o_data
);
    // Answer with an address pattern, toggle when not read
    always @(posedge i_mclk) begin
        if (i_rd)
            o_data <= {i_info, i_alt, i_addr[5:0]} ^ 8'h5a ^ {8{|i_addr[15:6]}};
        else
            o_data <= ~o_data;
    end
endmodule // flash_array_model

// [dv/flash_protect_option_loader_tb.sv]
`timescale 1ns/100ps
module flash_protect_option_loader_tb;
    typedef struct packed {logic [11:0] wa; logic [7:0] wd; logic [11:0] ra; logic [7:0] ex;} row_t;
    logic i_mclk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, i_stop_recover = 0, i_op_req = 0;
    logic i_op_info = 0, alt = 0, flash_rd, finfo, hold, info_sel, allow, blocked;
    logic [11:0] i_addr = 12'h000;
    logic [7:0] i_wdata = 8'h00, fdata, rdata, mask;
    logic [6:0] i_op_page = 7'h00, pg;
    logic [15:0] khz, faddr;
    logic [343:0] opt;
    int fail_count = 0, comparisons = 0, cycles = 0, n;
    row_t rows [8];
    logic [11:0] rst_addr [6] = '{12'hff6, 12'hff8, 12'hff9, 12'hffa, 12'hffb, 12'h100};

    always #4 i_mclk = ~i_mclk;

    flash_protect_option_loader u_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata),
        .i_stop_recover(i_stop_recover), .o_flash_rd(flash_rd), .o_flash_addr(faddr),
        .o_flash_info(finfo), .i_flash_data(fdata), .o_option_bytes(opt), .o_cpu_hold(hold),
        .o_flash_clock_khz(khz), .o_page_select(pg), .o_info_area_select(info_sel),
        .o_sector_lock_mask(mask), .i_op_req(i_op_req), .i_op_page(i_op_page),
        .i_op_info(i_op_info), .o_op_allow(allow), .o_op_blocked(blocked));
    flash_array_model u_flash (.i_mclk(i_mclk), .i_rd(flash_rd), .i_addr(faddr),
        .i_info(finfo), .i_alt(alt), .o_data(fdata));

    // Expected flash content
    function automatic logic [7:0] pat(input logic info, input logic a2, input logic [5:0] a);
        return {info, a2, a} ^ 8'h5a;
    endfunction

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        @(negedge i_mclk);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [7:0] ex, input string name);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        @(negedge i_mclk);
        chk(name, ex, rdata);
    endtask

    // Wait for the loader to let the processor go
    task automatic settle();
        n = 0;
        while (hold !== 1'b0 && n < 200) begin
            @(posedge i_mclk);
            n++;
            #1;
        end
    endtask

    task automatic opt_all(input logic a2);
        for (int k = 0; k < 43; k++)
            chk("option byte", pat(k > 1, a2, k[5:0]), opt[8*k+:8]);
    endtask

    task automatic op(input logic [6:0] p, input logic inf, input logic ex);
        @(posedge i_mclk);
        i_op_req <= 1'b1;
        i_op_page <= p;
        i_op_info <= inf;
        @(negedge i_mclk);
        chk("op allow", ex, allow);
        chk("op blocked", !ex, blocked);
    endtask

    task automatic conclude();
        if (fail_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Cut a hang short
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 4000) begin
            fail_count++;
            conclude();
        end
    end

    // Main sequence
    initial begin
        rows = '{'{12'hffa, 8'h12, 12'hffa, 8'h12}, '{12'hffb, 8'h34, 12'hffb, 8'h34},
            '{12'hff9, 8'h85, 12'hff9, 8'h85}, '{12'hff6, 8'h02, 12'hff7, pat(1, 0, 6'h22)},
            '{12'hff6, 8'h03, 12'hff6, 8'h03}, '{12'hff7, 8'hc3, 12'hff7, 8'hc3},
            '{12'hff6, 8'h20, 12'hff7, 8'h00}, '{12'hff8, 8'h5e, 12'hff8, 8'h04}};
        repeat (12) @(posedge i_mclk);
        chk("hold in reset", 1, hold);
        chk("lock mask reset", 0, mask);
        i_rst_n <= 1'b1;
        settle();
        chk("load cycles", 44, n);
        opt_all(0);
        foreach (rst_addr[i])
            rdc(rst_addr[i], 8'h00, "reset value");
        foreach (rows[i]) begin
            wr(rows[i].wa, rows[i].wd);
            rdc(rows[i].ra, rows[i].ex, "row read");
        end
        chk("clock khz", 16'h1234, khz);
        chk("page select", 16'h0085, {info_sel, pg});
        wr(12'hff9, 8'h03);
        chk("lock mask", 8'h03, mask);
        rdc(12'hff9, 8'h85, "page after lock");
        wr(12'hff8, 8'h5e);
        wr(12'hff9, 8'h00);
        chk("lock clear ignored", 8'h03, mask);
        wr(12'hff8, 8'h5e);
        wr(12'hff9, 8'h0c);
        chk("lock add", 8'h0f, mask);
        wr(12'hff8, 8'h73);
        wr(12'hff8, 8'h5e);
        wr(12'hff9, 8'h40);
        chk("lock after bad order", 8'h0f, mask);
        chk("page after bad order", 8'h40, {info_sel, pg});
        op(7'h02, 1'b0, 1'b0);
        op(7'h0a, 1'b0, 1'b1);
        op(7'h02, 1'b1, 1'b1);
        alt <= 1'b1;
        @(posedge i_mclk);
        chk("option before reload", pat(0, 0, 6'h00), opt[7:0]);
        i_stop_recover <= 1'b1;
        i_wr <= 1'b1;
        i_addr <= 12'hffa;
        i_wdata <= 8'hee;
        @(posedge i_mclk);
        i_stop_recover <= 1'b0;
        i_wr <= 1'b0;
        settle();
        chk("write during hold", 16'h1234, khz);
        opt_all(1);
        wr(12'hff6, 8'h03);
        rdc(12'hff7, pat(1, 1, 6'h23), "trim after reload");
        conclude();
    end
endmodule // flash_protect_option_loader_tb
